// File: verilog/sebfe_pkg.sv
package sebfe_pkg;

  // ==========================================================
  // Widths and counts
  localparam int unsigned  BYTE_W   = 8;
  localparam int unsigned  ADDR_W   = 16;
  localparam int unsigned  CODE_W   = 4;
  localparam logic [3:0]   CNT_LAST = 4'h7;   // Eighth bit of a byte
  localparam logic [3:0]   CNT_ACK  = 4'h8;   // Ninth clock: acknowledge slot

  // ==========================================================
  // Control byte layout, most significant bit first
  localparam int unsigned  CB_CODE_HI = 7;
  localparam int unsigned  CB_CODE_LO = 4;
  localparam int unsigned  CB_HALF    = 3;
  localparam int unsigned  CB_CS_HIGH = 2;
  localparam int unsigned  CB_CS_LOW  = 1;
  localparam int unsigned  CB_RW      = 0;
  localparam logic         RW_READ    = 1'b1;

  // Device-type code: arbitrary neutral value
  localparam logic [3:0]   DEV_CODE_DEFAULT = 4'h5;

  // ==========================================================
  // Word address
  localparam int unsigned  ADDR_TOP     = 15;  // top_array_address_bit
  localparam int unsigned  ADDR_HI_USED = 6;   // Top kept bit of the high address byte (bits 6:0 kept)
  localparam logic [15:0]  PTR_RST      = 16'h0000;
  localparam logic [7:0]   CTRL_RST     = 8'h00;

  // ==========================================================
  // Positions in the synchronised pin vector
  localparam int unsigned  PIN_N    = 8;
  localparam int unsigned  P_SCL    = 7;
  localparam int unsigned  P_SDA    = 6;
  localparam int unsigned  P_TGL    = 5;
  localparam int unsigned  P_BIT    = 4;
  localparam int unsigned  P_CS_LOW = 3;
  localparam int unsigned  P_CS_HI  = 2;
  localparam int unsigned  P_FIXED  = 1;
  localparam int unsigned  P_WP     = 0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } sebfe_state_t;

endpackage

// File: verilog/sebfe_sync.sv
`timescale 1ns/100ps
module sebfe_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,   // System clock
  input  wire logic         rstn,  // Synchronous reset, active low
  input  wire logic [W-1:0] din,   // Asynchronous levels
  output logic      [W-1:0] dout   // Levels after two flops
);

  // ==========================================================
  // Two-flop synchroniser
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sebfe_sync_t;

  sebfe_sync_t q;
  sebfe_sync_t d;

  if (W < 1) begin : g_chk
    $error("sebfe_sync: width must be at least one");
  end

  always_comb begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;  // First stage feeds only the second
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule

// File: verilog/sebfe_link_cap.sv
`timescale 1ns/100ps
module sebfe_link_cap (
  input  wire logic scl,      // Serial clock from the master
  input  wire logic rstn,     // Reset, active low
  input  wire logic sda_in,   // Serial data line level
  output logic      bit_val,  // Last bit sampled on a rising clock
  output logic      bit_tgl   // Flips once per sampled bit
);

  // ==========================================================
  // Bit capture on the link clock
  // The link clock stands still while idle, so the reset here
  // acts without it; flops only ever take constants from it.
  typedef struct packed {
    logic bv;
    logic tg;
  } sebfe_cap_t;

  sebfe_cap_t q;
  sebfe_cap_t d;

  always_comb begin
    d    = q;
    d.bv = sda_in;
    d.tg = ~q.tg;
  end

  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bit_val = q.bv;
  assign bit_tgl = q.tg;

endmodule

// File: verilog/sebfe_front_end.sv
// Notes on behaviour
// - Data falling while clock high is a Start; begin a new command.
// - Data rising while clock high is a Stop; end the current operation.
// - Data changes only with clock low; one bit per clock pulse.
// - Acknowledge each received addressed byte by holding data low all ack high.
// - Master not-acknowledges the last read byte; device then releases data.
// - During programming, withhold ack from a control byte equal to the write's.
// - Control byte: 4-bit type code, half-select, two chip selects, direction.
// - Half-select bit replaces address bit fifteen, choosing the segment.
// - Respond only when chip-select bits equal the two chip-address pins.
// - Direction bit one selects read, zero selects write.
// - Write control byte is followed by two address bytes, top bit ignored.
// - Ack the control byte only on match, then branch on direction.
// - Respond only while the fixed select pin is high; the code samples it only at a Start.
// - Write-protect high inhibits array writes; reads unaffected.
// - Sequential reads never leave the current segment or device.
// - Sequential read address wraps from segment end to segment start.
`timescale 1ns/100ps
module sebfe_front_end #(
  parameter logic [3:0] DEV_CODE = sebfe_pkg::DEV_CODE_DEFAULT  // Device-type code
) (
  input  wire logic        clk,                // System clock, 250 MHz
  input  wire logic        rstn,               // Synchronous reset, active low
  input  wire logic        scl,                // Serial clock pin, link clock
  input  wire logic        sda_in,             // Serial data pin level
  output logic             sda_out,            // Serial data drive value
  output logic             sda_oe_n,           // Serial data enable, low drives
  input  wire logic        chip_sel_pin_low,   // Chip-address pin, low select
  input  wire logic        chip_sel_pin_high,  // Chip-address pin, high select
  input  wire logic        fixed_select_pin,   // Must be high at a Start to operate
  input  wire logic        write_protect_pin,  // High inhibits writes
  input  wire logic        prog_busy,          // Internal write cycle running
  input  wire logic [7:0]  rd_data,            // Array byte at rd_addr
  output logic             rd_req,             // Pulse: fetch byte at rd_addr
  output logic      [15:0] rd_addr,            // Address pointer
  output logic             wr_strobe,          // Pulse: data byte received
  output logic      [15:0] wr_addr,            // Address of wr_data
  output logic      [7:0]  wr_data,            // Received data byte
  output logic             wr_commit,          // Pulse: start write cycle
  output logic             selected            // Device addressed and active
);

  // ==========================================================
  // State
  typedef struct packed {
    sebfe_pkg::sebfe_state_t st;
    logic [3:0]              cnt;
    logic [7:0]              sh;
    logic [7:0]              tx;
    logic [7:0]              ctrl;
    logic [7:0]              poll;
    logic [15:0]             ptr;
    logic [15:0]             waddr;
    logic [7:0]              wdata;
    logic                    drv;
    logic                    ackw;
    logic                    load;
    logic                    wpend;
    logic                    ev;
    logic                    tgl_prev;
    logic                    scl_prev;
    logic                    sda_prev;
    logic                    rreq;
    logic                    wstb;
    logic                    commit;
  } sebfe_regs_t;

  sebfe_regs_t q;
  sebfe_regs_t d;

  logic                           cap_bit;
  logic                           cap_tgl;
  logic [sebfe_pkg::PIN_N-1:0]    pins_s;
  logic                           scl_s;
  logic                           sda_s;
  logic                           tgl_s;
  logic                           bit_s;
  logic                           cs_low_s;
  logic                           cs_high_s;
  logic                           fixed_s;
  logic                           wp_s;
  logic [7:0]                     byte_v;
  logic                           start_c;
  logic                           stop_c;
  logic                           fall_c;

  // ==========================================================
  // Helpers
  // Increment inside the segment; the half bit never changes
  function automatic logic [15:0] seg_inc(input logic [15:0] a);
    seg_inc = {a[sebfe_pkg::ADDR_TOP], a[14:0] + 15'h0001};
  endfunction

  function automatic logic ctrl_hit(input logic [7:0] c,
                                    input logic       cs_hi,
                                    input logic       cs_lo);
    ctrl_hit = (c[sebfe_pkg::CB_CODE_HI:sebfe_pkg::CB_CODE_LO] == DEV_CODE) &&
               (c[sebfe_pkg::CB_CS_HIGH] == cs_hi) &&
               (c[sebfe_pkg::CB_CS_LOW] == cs_lo);
  endfunction

  // ==========================================================
  // Link domain and crossings
  sebfe_link_cap u_cap (
    .scl     (scl),
    .rstn    (rstn),
    .sda_in  (sda_in),
    .bit_val (cap_bit),
    .bit_tgl (cap_tgl)
  );

  // Captured bit is held a whole clock period, so it crosses
  // beside its toggle and is read one cycle after the toggle moves
  sebfe_sync #(
    .W (sebfe_pkg::PIN_N)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  ({scl, sda_in, cap_tgl, cap_bit, chip_sel_pin_low,
            chip_sel_pin_high, fixed_select_pin, write_protect_pin}),
    .dout (pins_s)
  );

  assign scl_s     = pins_s[sebfe_pkg::P_SCL];
  assign sda_s     = pins_s[sebfe_pkg::P_SDA];
  assign tgl_s     = pins_s[sebfe_pkg::P_TGL];
  assign bit_s     = pins_s[sebfe_pkg::P_BIT];
  assign cs_low_s  = pins_s[sebfe_pkg::P_CS_LOW];
  assign cs_high_s = pins_s[sebfe_pkg::P_CS_HI];
  assign fixed_s   = pins_s[sebfe_pkg::P_FIXED];
  assign wp_s      = pins_s[sebfe_pkg::P_WP];

  // ==========================================================
  // Bus conditions seen on the oversampled lines
  assign start_c = scl_s && q.scl_prev && q.sda_prev && !sda_s;
  assign stop_c  = scl_s && q.scl_prev && !q.sda_prev && sda_s;
  assign fall_c  = q.scl_prev && !scl_s;
  assign byte_v  = {q.sh[6:0], bit_s};

  // ==========================================================
  // Protocol engine
  always_comb begin
    d          = q;
    d.rreq     = 1'b0;
    d.wstb     = 1'b0;
    d.commit   = 1'b0;
    d.tgl_prev = tgl_s;
    d.ev       = (tgl_s != q.tgl_prev);
    d.scl_prev = scl_s;
    d.sda_prev = sda_s;

    // One sampled bit per rising clock
    if (q.ev) begin
      if (q.cnt == sebfe_pkg::CNT_ACK) begin
        d.cnt = 4'h0;
        if (q.st == sebfe_pkg::ST_RDATA) begin
          if (q.ackw) begin
            d.load = 1'b1;
          end else if (!bit_s) begin
            d.load = 1'b1;
          end else begin
            d.st = sebfe_pkg::ST_IGNORE;
          end
        end
      end else begin
        d.sh  = byte_v;
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == sebfe_pkg::CNT_LAST) begin
          d.ackw = 1'b0;
          case (q.st)
            sebfe_pkg::ST_CTRL: begin
              d.ctrl = byte_v;
              if (ctrl_hit(byte_v, cs_high_s, cs_low_s) &&
                  !(prog_busy && byte_v == q.poll)) begin
                d.ackw = 1'b1;
                d.ptr[sebfe_pkg::ADDR_TOP] = byte_v[sebfe_pkg::CB_HALF];
                if (byte_v[sebfe_pkg::CB_RW] == sebfe_pkg::RW_READ) begin
                  d.st   = sebfe_pkg::ST_RDATA;
                  d.rreq = 1'b1;
                end else begin
                  d.st = sebfe_pkg::ST_ADDR_HI;
                end
              end else begin
                d.st = sebfe_pkg::ST_IGNORE;
              end
            end
            sebfe_pkg::ST_ADDR_HI: begin
              d.ptr[14:8] = byte_v[sebfe_pkg::ADDR_HI_USED:0];
              d.ackw      = 1'b1;
              d.st        = sebfe_pkg::ST_ADDR_LO;
            end
            sebfe_pkg::ST_ADDR_LO: begin
              d.ptr[7:0] = byte_v;
              d.ackw     = 1'b1;
              d.st       = sebfe_pkg::ST_WDATA;
            end
            sebfe_pkg::ST_WDATA: begin
              d.wdata = byte_v;
              d.waddr = q.ptr;
              d.wstb  = 1'b1;
              d.ptr   = seg_inc(q.ptr);
              d.wpend = 1'b1;
              d.ackw  = 1'b1;
            end
            sebfe_pkg::ST_RDATA: begin
              // Prefetch the next byte; the pointer never leaves the segment
              d.ptr  = seg_inc(q.ptr);
              d.rreq = 1'b1;
            end
            default: begin
              d.ackw = 1'b0;
            end
          endcase
        end
      end
    end

    // Drive changes after a falling clock, or is released at a Start or Stop
    if (fall_c) begin
      if (q.cnt == sebfe_pkg::CNT_ACK) begin
        d.drv = q.ackw;
      end else if (q.st == sebfe_pkg::ST_RDATA) begin
        if (q.load && q.cnt == 4'h0) begin
          d.tx   = rd_data;
          d.load = 1'b0;
          d.drv  = ~rd_data[7];
        end else begin
          d.drv = ~q.tx[~q.cnt[2:0]];
        end
      end else begin
        d.drv = 1'b0;
      end
    end

    // Conditions override the state, drive, ack and load set by bit work in the same cycle
    if (stop_c) begin
      d.st   = sebfe_pkg::ST_IDLE;
      d.drv  = 1'b0;
      d.ackw = 1'b0;
      d.load = 1'b0;
      if (q.wpend) begin
        d.wpend = 1'b0;
        // Protect is sampled at the Stop that would launch the write
        if (!wp_s) begin
          d.commit = 1'b1;
          d.poll   = q.ctrl;
        end
      end
    end else if (start_c) begin
      d.cnt   = 4'h0;
      d.drv   = 1'b0;
      d.ackw  = 1'b0;
      d.load  = 1'b0;
      d.wpend = 1'b0;
      d.st    = fixed_s ? sebfe_pkg::ST_CTRL : sebfe_pkg::ST_IGNORE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      q      <= '0;
      q.st   <= sebfe_pkg::ST_IDLE;
      q.ptr  <= sebfe_pkg::PTR_RST;
      q.ctrl <= sebfe_pkg::CTRL_RST;
      q.poll <= sebfe_pkg::CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  // Open-drain: the line is only ever pulled low or released
  assign sda_out   = 1'b0;
  assign sda_oe_n  = ~q.drv;
  assign rd_req    = q.rreq;
  assign rd_addr   = q.ptr;
  assign wr_strobe = q.wstb;
  assign wr_addr   = q.waddr;
  assign wr_data   = q.wdata;
  assign wr_commit = q.commit;
  assign selected  = (q.st == sebfe_pkg::ST_ADDR_HI) || (q.st == sebfe_pkg::ST_ADDR_LO) ||
                     (q.st == sebfe_pkg::ST_WDATA) || (q.st == sebfe_pkg::ST_RDATA);

endmodule

// File: bench/sebfe_chk_assertions.sv
`timescale 1ns/100ps
module sebfe_chk (
  input wire logic        clk,                // System clock
  input wire logic        rstn,               // Reset, active low
  input wire logic        scl,                // Bus clock
  input wire logic        sda_out,            // Drive value
  input wire logic        sda_oe_n,           // Drive enable, low drives
  input wire logic        write_protect_pin,  // Write protect
  input wire logic        rd_req,             // Fetch pulse
  input wire logic [15:0] rd_addr,            // Address pointer
  input wire logic        wr_strobe,          // Data byte pulse
  input wire logic [15:0] wr_addr,            // Write address
  input wire logic [7:0]  wr_data,            // Write data
  input wire logic        wr_commit,          // Write cycle pulse
  input wire logic        selected            // Addressed and active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Helpers: protect level age, address of the previous fetch
  logic [3:0]  wp_cnt_q, wp_cnt_d;
  logic [15:0] prev_q, prev_d;
  always_comb begin
    wp_cnt_d = write_protect_pin ? ((wp_cnt_q == 4'hF) ? wp_cnt_q : wp_cnt_q + 4'h1) : 4'h0;
    prev_d   = rd_req ? rd_addr : prev_q;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wp_cnt_q <= 4'h0;
      prev_q   <= 16'h0000;
    end else begin
      wp_cnt_q <= wp_cnt_d;
      prev_q   <= prev_d;
    end
  end

  // ==========================================================
  // Properties
  property p_drive_low; !sda_oe_n |-> sda_out == 1'b0; endproperty
  property p_drive_scl_low; $fell(sda_oe_n) |-> !scl; endproperty
  property p_rd_pulse; rd_req |=> !rd_req; endproperty
  // Depth 8 keeps the control byte's own fetch out of the step check
  property p_seq_step; rd_req && $past(selected, 8) |-> rd_addr == {prev_q[15], prev_q[14:0] + 15'h0001}; endproperty
  property p_seg; rd_req && $past(selected, 8) |-> rd_addr[15] == prev_q[15]; endproperty
  property p_commit_scl; wr_commit |-> scl && $past(scl, 2); endproperty
  property p_commit_wp; wr_commit |-> wp_cnt_q < 4'hC; endproperty
  property p_strobe_scl; wr_strobe |-> scl && sda_oe_n; endproperty
  property p_waddr_hold; $changed(wr_addr) || $changed(wr_data) |-> wr_strobe; endproperty

  a_drive_low: assert property (p_drive_low) else $error("data driven high");
  a_drive_scl_low: assert property (p_drive_scl_low) else $error("drive began with clock high");
  a_rd_pulse: assert property (p_rd_pulse) else $error("fetch pulse too long");
  a_seq_step: assert property (p_seq_step) else $error("sequential step wrong");
  a_seg: assert property (p_seg) else $error("segment bit changed");
  a_commit_scl: assert property (p_commit_scl) else $error("commit without stop");
  a_commit_wp: assert property (p_commit_wp) else $error("commit while protected");
  a_strobe_scl: assert property (p_strobe_scl) else $error("strobe off clock high");
  a_waddr_hold: assert property (p_waddr_hold) else $error("write bus moved");

  c_commit: cover property (wr_commit);
  c_seq: cover property (rd_req && $past(selected, 8));
  c_ack: cover property ($fell(sda_oe_n));
endmodule

bind sebfe_front_end sebfe_chk i_sebfe_chk (.*);

// File: bench/sebfe_master.sv
`timescale 1ns/100ps
module sebfe_master (
  output logic      scl,    // Bus clock, idles high
  output logic      sda_m,  // Data drive, low pulls the line
  input  wire logic sda     // Resolved data line
);
  // ==========================================================
  // Idle bus, clock still between frames
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // Data moves mid low phase, clear of the device's sync delay
  task automatic xfer_bit(input logic b, output logic s);
    #50 sda_m = b;
    #50.3 scl = 1'b1;
    #50 s = sda;
    #50.3 scl = 1'b0;
  endtask

  task automatic start();
    #50 sda_m = 1'b1;
    #50.3 scl = 1'b1;
    #50 sda_m = 1'b0;
    #50.3 scl = 1'b0;
  endtask

  task automatic stop();
    #50 sda_m = 1'b0;
    #50.3 scl = 1'b1;
    #50 sda_m = 1'b1;
    #50.3;
  endtask

  // Ninth clock is the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic ack_bit, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r[i]);
    xfer_bit(ack_bit, a);
  endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/100ps
module tb;
  // ==========================================================
  // Pins and bookkeeping
  logic        clk               = 1'b0;
  logic        rstn              = 1'b0;
  logic        chip_sel_pin_low  = 1'b0;
  logic        chip_sel_pin_high = 1'b1;
  logic        fixed_select_pin  = 1'b1;
  logic        write_protect_pin = 1'b0;
  logic        prog_busy         = 1'b0;
  logic [7:0]  rd_data           = 8'h00;
  logic [15:0] wa_q              = 16'h0000;
  logic [7:0]  wd_q              = 8'h00;
  wire         scl, sda_m, sda_out, sda_oe_n, rd_req, wr_strobe, wr_commit, selected;
  wire  [15:0] rd_addr, wr_addr;
  wire  [7:0]  wr_data;
  int          miscompares = 0, samples_checked = 0, n_cm = 0, cyc = 0;
  // Pull-up: any party pulling low wins
  wire         sda_in = sda_m & (sda_oe_n | sda_out);

  always #2 clk = ~clk;

  sebfe_front_end i_sebfe_front_end (.*);
  sebfe_master i_sebfe_master (.scl(scl), .sda_m(sda_m), .sda(sda_in));

  // Array stand-in: byte reads back as address high xor low
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_req === 1'b1) rd_data <= #1 rd_addr[7:0] ^ rd_addr[15:8];
    if (wr_strobe === 1'b1) begin
      wa_q <= wr_addr;
      wd_q <= wr_data;
    end
    if (wr_commit === 1'b1) n_cm <= n_cm + 1;
    if (cyc == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] cb(input logic half, input logic rw);
    return {sebfe_pkg::DEV_CODE_DEFAULT, half, chip_sel_pin_high, chip_sel_pin_low, rw};
  endfunction

  task automatic wb(input logic [7:0] d, input logic exp);
    logic [7:0] r;
    logic       a;
    i_sebfe_master.byte_io(d, 1'b1, r, a);
    chk("ack line", 16'(exp), 16'(a));
  endtask

  task automatic rb(input logic ack_bit, input logic [7:0] exp);
    logic [7:0] r;
    logic       a;
    i_sebfe_master.byte_io(8'hFF, ack_bit, r, a);
    chk("read byte", 16'(exp), 16'(r));
    chk("ninth bit line", 16'(ack_bit), 16'(a));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_write;
    i_sebfe_master.start();
    wb(cb(1'b1, 1'b0), 1'b0);
    wb(8'hFF, 1'b0);
    wb(8'hFE, 1'b0);
    wb(8'h5A, 1'b0);
    chk("write address", 16'hFFFE, wa_q);
    wb(8'hC3, 1'b0);
    chk("write address", 16'hFFFF, wa_q);
    chk("write data", 16'h00C3, 16'(wd_q));
    i_sebfe_master.stop();
    chk("commits", 16'h0001, 16'(n_cm));
    $display("write test done");
  endtask

  task automatic t_poll;
    @(posedge clk) #1 prog_busy = 1'b1;
    i_sebfe_master.start();
    wb(cb(1'b1, 1'b0), 1'b1);
    i_sebfe_master.start();
    wb(cb(1'b0, 1'b1), 1'b0);
    rb(1'b1, 8'h00);
    i_sebfe_master.stop();
    @(posedge clk) #1 prog_busy = 1'b0;
    i_sebfe_master.start();
    wb(cb(1'b1, 1'b0), 1'b0);
    i_sebfe_master.stop();
    $display("poll test done");
  endtask

  task automatic t_mismatch;
    logic [7:0] m [3] = '{8'h80, 8'h04, 8'h02};
    foreach (m[i]) begin
      i_sebfe_master.start();
      wb(cb(1'b1, 1'b0) ^ m[i], 1'b1);
      wb(8'h00, 1'b1);
      i_sebfe_master.stop();
    end
    @(posedge clk) #1 fixed_select_pin = 1'b0;
    i_sebfe_master.start();
    wb(cb(1'b1, 1'b0), 1'b1);
    i_sebfe_master.stop();
    @(posedge clk) #1 fixed_select_pin = 1'b1;
    chk("commits", 16'h0001, 16'(n_cm));
    $display("mismatch test done");
  endtask

  task automatic t_wp;
    @(posedge clk) #1 write_protect_pin = 1'b1;
    i_sebfe_master.start();
    wb(cb(1'b0, 1'b0), 1'b0);
    wb(8'h00, 1'b0);
    wb(8'h10, 1'b0);
    wb(8'h77, 1'b0);
    chk("write address", 16'h0010, wa_q);
    i_sebfe_master.stop();
    chk("commits", 16'h0001, 16'(n_cm));
    @(posedge clk) #1 write_protect_pin = 1'b0;
    $display("protect test done");
  endtask

  task automatic t_read;
    i_sebfe_master.start();
    wb(cb(1'b0, 1'b0), 1'b0);
    wb(8'hFF, 1'b0);
    wb(8'hFF, 1'b0);
    i_sebfe_master.start();
    wb(cb(1'b0, 1'b1), 1'b0);
    rb(1'b0, 8'h80);
    rb(1'b0, 8'h00);
    rb(1'b1, 8'h01);
    i_sebfe_master.stop();
    chk("commits", 16'h0001, 16'(n_cm));
    $display("read test done");
  endtask

  task automatic t_abort;
    logic s;
    i_sebfe_master.start();
    for (int i = 0; i < 4; i++) i_sebfe_master.xfer_bit(1'b0, s);
    i_sebfe_master.start();
    wb(cb(1'b1, 1'b1), 1'b0);
    rb(1'b1, 8'h82);
    i_sebfe_master.stop();
    $display("abort test done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (8) @(posedge clk);
    t_write;
    t_poll;
    t_mismatch;
    t_wp;
    t_read;
    t_abort;
    tally_and_finish;
  end
endmodule
